/* pio_top.sv */
// parallel i/o ports: two bidirectional ports and one input-only port
`timescale 1ns/1ns
`default_nettype none
module pio_top (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic [7:0] first_bidir_port_pins_i,
   output logic [7:0] first_bidir_port_pins_o,
   output logic [7:0] first_bidir_port_pins_oe,
   input wire logic [7:0] second_bidir_port_pins_i,
   output logic [7:0] second_bidir_port_pins_o,
   output logic [7:0] second_bidir_port_pins_oe,
   input wire logic [3:0] input_only_port_pins
);
   import pio_pkg::*;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [7:0] first_sync;
   logic [7:0] second_sync;
   logic [3:0] inp_sync;

   pio_sync #(.W(8)) u_sync_first (
      .ref_clk(ref_clk),
      .rst_n(rst_n_q),
      .async_in(first_bidir_port_pins_i),
      .sync_out(first_sync)
   );
   pio_sync #(.W(8)) u_sync_second (
      .ref_clk(ref_clk),
      .rst_n(rst_n_q),
      .async_in(second_bidir_port_pins_i),
      .sync_out(second_sync)
   );
   pio_sync #(.W(4)) u_sync_inp (
      .ref_clk(ref_clk),
      .rst_n(rst_n_q),
      .async_in(input_only_port_pins),
      .sync_out(inp_sync)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic wr_first_data;
   logic wr_second_data;
   logic wr_first_dir;
   logic wr_second_dir;

   assign wr_first_data = wr_stb && (addr == PIO_OFS_DATA_FIRST);
   assign wr_second_data = wr_stb && (addr == PIO_OFS_DATA_SECOND);
   assign wr_first_dir = wr_stb && (addr == PIO_OFS_DIR_FIRST);
   assign wr_second_dir = wr_stb && (addr == PIO_OFS_DIR_SECOND);

   // ----------------------------------------
   // ports
   // ----------------------------------------
   pio_drive_t first_drv;
   pio_drive_t second_drv;
   logic [7:0] first_rd;
   logic [7:0] second_rd;
   logic [7:0] first_dir;
   logic [7:0] second_dir;

   pio_port u_first (
      .ref_clk(ref_clk),
      .rst_n(rst_n_q),
      .data_wr(wr_first_data),
      .dir_wr(wr_first_dir),
      .wdata(wdata),
      .pin_sync(first_sync),
      .drive(first_drv),
      .data_rd(first_rd),
      .dir_rd(first_dir)
   );
   pio_port u_second (
      .ref_clk(ref_clk),
      .rst_n(rst_n_q),
      .data_wr(wr_second_data),
      .dir_wr(wr_second_dir),
      .wdata(wdata),
      .pin_sync(second_sync),
      .drive(second_drv),
      .data_rd(second_rd),
      .dir_rd(second_dir)
   );

   assign first_bidir_port_pins_o = first_drv.o;
   assign first_bidir_port_pins_oe = first_drv.oe;
   assign second_bidir_port_pins_o = second_drv.o;
   assign second_bidir_port_pins_oe = second_drv.oe;

   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   logic [7:0] rdata_d;

   always_comb begin
      case (addr)
         PIO_OFS_DATA_FIRST: rdata_d = first_rd;
         PIO_OFS_DATA_SECOND: rdata_d = second_rd;
         PIO_OFS_DATA_INPUT: rdata_d = {PIO_INP_FILL, inp_sync};
         PIO_OFS_DIR_FIRST: rdata_d = first_dir;
         PIO_OFS_DIR_SECOND: rdata_d = second_dir;
         default: rdata_d = PIO_UNMAPPED;
      endcase
   end

   // holds zero outside the answer cycle
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         rdata <= rdata_d;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* pio_pkg.sv */
// package: constants and types of the parallel i/o ports block
package pio_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int PIO_PORT_W = 8;
   localparam int PIO_INP_W = 4;
   localparam int PIO_ADDR_W = 3;

   // ----------------------------------------
   // offsets
   // ----------------------------------------
   localparam logic [2:0] PIO_OFS_DATA_FIRST = 3'h0;
   localparam logic [2:0] PIO_OFS_DATA_SECOND = 3'h1;
   localparam logic [2:0] PIO_OFS_DATA_INPUT = 3'h2;
   localparam logic [2:0] PIO_OFS_DIR_FIRST = 3'h4;
   localparam logic [2:0] PIO_OFS_DIR_SECOND = 3'h5;

   // ----------------------------------------
   // reset values and fills
   // ----------------------------------------
   localparam logic [7:0] PIO_DIR_RESET = 8'h00;
   localparam logic [3:0] PIO_INP_FILL = 4'hF;
   localparam logic [7:0] PIO_UNMAPPED = 8'h00;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } pio_drive_t;
endpackage

/* pio_sync.sv */
// two flip-flop synchroniser of a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module pio_sync #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // first stage read only by second stage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* pio_port.sv */
// one bidirectional 8-bit port: latch, direction and read mux
`timescale 1ns/1ns
`default_nettype none
module pio_port (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic data_wr,
   input wire logic dir_wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] pin_sync,
   output pio_pkg::pio_drive_t drive,
   output logic [7:0] data_rd,
   output logic [7:0] dir_rd
);
   import pio_pkg::*;

   logic [7:0] latch_q;
   logic [7:0] dir_q;

   // ----------------------------------------
   // output latch
   // ----------------------------------------
   // no reset: the latch keeps its value across reset
   always_ff @(posedge ref_clk) begin
      if (data_wr) begin
         latch_q <= wdata;
      end
   end

   // ----------------------------------------
   // direction
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= PIO_DIR_RESET;
      end else if (dir_wr) begin
         dir_q <= wdata;
      end
   end

   // output gated by direction, enable is the direction; latch undefined after power-up only shows once driven
   // one continuous assignment for the whole struct: it is a single variable
   assign drive = '{o: latch_q & dir_q, oe: dir_q};
   assign data_rd = (dir_q & latch_q) | (~dir_q & pin_sync);
   assign dir_rd = dir_q;
endmodule
`default_nettype wire

/* pio_pin_model.sv */
// board-side model of one bidirectional port's pins
`timescale 1ns/1ns
`default_nettype none
module pio_pin_model (
   input wire logic [7:0] o,
   input wire logic [7:0] oe,
   input wire logic [7:0] ext,
   output logic [7:0] level
);
   // ------
   // pin level
   // ------
   // undriven bits follow the board source, never the last driven value
   assign level = (o & oe) | (ext & ~oe);
endmodule
`default_nettype wire

/* pio_top_checker.sv */
// assertions on the ports of the parallel i/o top
`timescale 1ns/1ns
`default_nettype none
module pio_top_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic [7:0] first_bidir_port_pins_o,
   input wire logic [7:0] first_bidir_port_pins_oe,
   input wire logic [7:0] second_bidir_port_pins_o,
   input wire logic [7:0] second_bidir_port_pins_oe
);
   wire logic [7:0] o1 = first_bidir_port_pins_o;
   wire logic [7:0] e1 = first_bidir_port_pins_oe;
   wire logic [7:0] o2 = second_bidir_port_pins_o;
   wire logic [7:0] e2 = second_bidir_port_pins_oe;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ------
   // properties
   // ------
   rst_dir_a: assert property (disable iff (1'b0) !reset_n |=> (e1 | e2) == 8'h00)
      else $error("direction left set by reset");
   dir_one_a: assert property (wr_stb && addr == 3'h4 |=> e1 == $past(wdata))
      else $error("first direction write lost");
   dir_two_a: assert property (wr_stb && addr == 3'h5 |=> e2 == $past(wdata))
      else $error("second direction write lost");
   dir_hold_a: assert property (!(wr_stb && addr == 3'h4) |=> $stable(e1))
      else $error("direction moved without write");
   out_one_a: assert property (wr_stb && addr == 3'h0 |=> o1 == ($past(wdata) & e1))
      else $error("first port drive wrong");
   out_two_a: assert property (wr_stb && addr == 3'h1 |=> o2 == ($past(wdata) & e2))
      else $error("second port drive wrong");
   idle_read_a: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("read data outside read slot");
   inp_fill_a: assert property (rd_stb && addr == 3'h2 |=> rdata[7:4] == 4'hF)
      else $error("input port upper bits wrong");
   latch_read_a: assert property (rd_stb && addr == 3'h0 |=> ((rdata ^ o1) & e1) == 8'h00)
      else $error("output bits not read from latch");
   gap_read_a: assert property (rd_stb && addr inside {3'h3, 3'h6, 3'h7} |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property (wr_stb && addr == 3'h4);
   cover property (rd_stb && addr == 3'h2);
   cover property (rd_stb && addr == 3'h0 && e1 != 8'h00);
endmodule
bind pio_top pio_top_checker chk (.*);
`default_nettype wire

/* test_parallel_io_ports.sv */
// self-checking bench of the parallel i/o ports
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module test_parallel_io_ports;
   logic ref_clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, rv = 0;
   logic [2:0] addr = 3'h0;
   logic [3:0] inp = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, ev, lat [2], dir [2], ext [2] = '{8'h00, 8'h00};
   logic [7:0] q [$];
   logic [31:0] seed = 87;
   int err_count = 0, comparisons = 0;
   wire logic [7:0] o [2], oe [2], pin [2];
   // ------
   // design and board model
   // ------
   pio_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .input_only_port_pins(inp),
      .first_bidir_port_pins_i(pin[0]), .first_bidir_port_pins_o(o[0]),
      .first_bidir_port_pins_oe(oe[0]), .second_bidir_port_pins_i(pin[1]),
      .second_bidir_port_pins_o(o[1]), .second_bidir_port_pins_oe(oe[1]));
   pio_pin_model pa (.o(o[0]), .oe(oe[0]), .ext(ext[0]), .level(pin[0]));
   pio_pin_model pb (.o(o[1]), .oe(oe[1]), .ext(ext[1]), .level(pin[1]));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a; wdata <= d; wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      q.push_back(e);
      @(posedge ref_clk);
      addr <= a; rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1;
   endtask
   task automatic complete_run();
      $display("err_count %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ------
   // clock, read monitor, watchdog
   // ------
   initial forever #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      rv <= rd_stb;
      if (rv) begin
         ev = q.pop_front();
         `CHK(rdata, ev)
      end
   end
   initial begin
      #300000;
      err_count++;
      complete_run();
   end
   // ------
   // scenarios
   // ------
   initial begin
      int p;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(3'h4, 8'h00);
      rd(3'h5, 8'h00);
      for (int i = 0; i < 24; i++) begin
         p = i % 2;
         @(posedge ref_clk);
         ext[p] <= 8'(xs()); inp <= 4'(xs()); dir[p] = 8'(xs()); lat[p] = 8'(xs());
         wr(3'(p + 4), dir[p]);
         wr(3'(p), lat[p]);
         `CHK(oe[p], dir[p])
         `CHK(o[p], lat[p] & dir[p])
         repeat (2) @(posedge ref_clk);
         // the sync stages need two edges before the new board value reads back
         rd(3'(p), (lat[p] & dir[p]) | (ext[p] & ~dir[p]));
         rd(3'h2, {4'hF, inp});
         rd(3'(p + 4), dir[p]);
      end
      wr(3'h3, 8'hFF);
      rd(3'h3, 8'h00);
      rd(3'h6, 8'h00);
      rd(3'h7, 8'h00);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK(oe[0] | oe[1], 8'h00)
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      wr(3'h4, 8'hFF);
      rd(3'h0, lat[0]);
      repeat (3) @(posedge ref_clk);
      complete_run();
   end
endmodule
`default_nettype wire
